/* File: design/csm_top.sv */
`timescale 1ns/1ns

// What this block does
// - mode register is written by byte or single-bit style writes.
// - external reset clears the mode register to zero, monitor off.
// - bit 0 of the mode register enables monitoring when one.
// - enable bit is sticky; only external or internal reset clears it.
// - monitor-caused reset clears enable and sets cause flag bit 1.
// - monitoring begins once the enable bit is one.
// - monitor waits out the settle period after any reset release.
// - monitor suspended in stop mode and during the following settle.
// - monitor suspended while software halts the fast clock, then settle.
// - monitor suspended while the internal oscillator is halted.
// - monitor runs only outside stop and reset with both clocks running.
// - enable set during settle waits and starts when settle ends.
// - settle wait applies always, whatever fast clock source is used.
// - enable set before stop resumes after post-stop settle by itself.
// - enable set during software halt starts after restart and settle.
// - fast clock halt bits are bit 7 of two control registers.
// - oscillator halt bit writes ignored when halting is not allowed.
// - watchdog, voltage or monitor resets only set their own flag.
// - power-on clear zeroes every cause flag.
// - running monitor samples fast clock and resets the chip on stop.
// - reading the cause register zeroes its flags.
module csm_top #(
	parameter int unsigned SETTLE_CYCLES = 32'(csm_pkg::SETTLE_CYCLES_DEF)
) (
	// clock and external reset
	input wire logic clk_sys,
	input wire logic rst,
	// register bus
	input wire csm_pkg::csm_axi_req_t axi_req,
	output csm_pkg::csm_axi_rsp_t axi_rsp,
	// fast clock pin and chip status
	input wire logic hs_clk_pin,
	input wire logic stop_mode,
	input wire logic osc_stop_allowed,
	input wire logic main_clock_selected,
	// other reset sources
	input wire logic por_req,
	input wire logic wdt_reset_req,
	input wire logic lvi_reset_req,
	// outputs to chip
	output logic clk_stop_reset,
	output logic monitor_active,
	output logic main_osc_halt,
	output logic main_clock_cut,
	output logic internal_osc_halt
);
	import csm_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	csm_axi_rsp_t rsp_reg;
	csm_state_t state_reg;
	logic [SETTLE_W-1:0] settle_cnt_reg;
	logic [4:0] gap_cnt_reg;
	logic hs_meta_reg, hs_sync_reg, hs_last_reg, watch_enable_reg;
	logic [7:0] reset_cause_register;
	logic mosc_halt_reg, cpu_cut_reg, iosc_halt_reg;
	logic clk_stop_reset_reg, monitor_active_reg;
	logic aw_ok_reg, w_ok_reg, wstrb0_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic hs_edge, sw_stop, suspend, mon_on, detect, int_any;
	logic wr_fire, rd_fire, cause_read;

	// true when the address is one of the mapped words
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == ADDR_MODE) || (a == ADDR_CAUSE) ||
			(a == ADDR_MOSC) || (a == ADDR_CPUCLK) ||
			(a == ADDR_IOSC) || (a == ADDR_MCLK) ||
			(a == ADDR_STATUS);
	endfunction

	// read data for a mapped word, zero elsewhere
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_MODE: v[BIT_WATCH_EN] = watch_enable_reg;
			ADDR_CAUSE: v = reset_cause_register;
			ADDR_MOSC: v[BIT_HS_HALT] = mosc_halt_reg;
			ADDR_CPUCLK: v[BIT_HS_HALT] = cpu_cut_reg;
			ADDR_IOSC: v[BIT_IOSC_HALT] = iosc_halt_reg;
			ADDR_MCLK: v[BIT_MCLK_SEL] = main_clock_selected;
			ADDR_STATUS: v = {5'h00, state_reg == ST_HOLD,
				state_reg == ST_SETTLE, mon_on};
			default: v = 8'h00;
		endcase
		rd_mux = {24'h00_0000, v};
	endfunction

	// ---------------------------------------------------------------
	// fast clock sampling
	// ---------------------------------------------------------------
	// two-stage synchroniser then edge detect on the second stage
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			{hs_meta_reg, hs_sync_reg, hs_last_reg} <= 3'b000;
		else
		begin
			hs_meta_reg <= hs_clk_pin;
			hs_sync_reg <= hs_meta_reg;
			hs_last_reg <= hs_sync_reg;
		end
	end

	// monitor conditions
	assign hs_edge = hs_sync_reg ^ hs_last_reg;
	assign sw_stop = mosc_halt_reg | cpu_cut_reg;
	assign suspend = stop_mode | sw_stop;
	// only stabilised, enabled, oscillator running
	assign mon_on = (state_reg == ST_RUN) && watch_enable_reg &&
		!iosc_halt_reg;
	assign detect = mon_on && !hs_edge &&
		(gap_cnt_reg == STOP_WINDOW_CYCLES - 5'h01);
	assign int_any = detect | wdt_reset_req | lvi_reset_req | por_req;

	// ---------------------------------------------------------------
	// suspension and settle sequencing
	// ---------------------------------------------------------------
	// any reset restarts the full settle wait; suspension holds it and reloads the full count
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_SETTLE;
			settle_cnt_reg <= SETTLE_W'(SETTLE_CYCLES);
		end
		else if (int_any)
		begin
			state_reg <= ST_SETTLE;
			settle_cnt_reg <= SETTLE_W'(SETTLE_CYCLES);
		end
		else if (suspend)
		begin
			state_reg <= ST_HOLD;
			settle_cnt_reg <= SETTLE_W'(SETTLE_CYCLES);
		end
		else
		begin
			case (state_reg)
				ST_HOLD: state_reg <= ST_SETTLE;
				ST_SETTLE:
				begin
					// same wait whatever the fast clock source
					if (settle_cnt_reg == '0)
						state_reg <= ST_RUN;
					else
						settle_cnt_reg <= settle_cnt_reg - 1'b1;
				end
				ST_RUN: state_reg <= ST_RUN;
				default: state_reg <= ST_SETTLE;
			endcase
		end
	end

	// edge gap counter, idle unless monitoring
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			gap_cnt_reg <= 5'h00;
		else if (!mon_on || hs_edge)
			gap_cnt_reg <= 5'h00;
		else
			gap_cnt_reg <= gap_cnt_reg + 5'h01;
	end

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	assign wr_fire = aw_ok_reg && w_ok_reg && !rsp_reg.bvalid;
	assign rd_fire = axi_req.arvalid && rsp_reg.arready;
	assign cause_read = rd_fire && (axi_req.araddr[7:0] == ADDR_CAUSE);

	// write address and data latched independently
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			aw_ok_reg <= 1'b0;
			w_ok_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb0_reg <= 1'b0;
		end
		else
		begin
			if (axi_req.awvalid && rsp_reg.awready)
			begin
				aw_ok_reg <= 1'b1;
				awaddr_reg <= axi_req.awaddr[7:0];
			end
			else if (wr_fire)
				aw_ok_reg <= 1'b0;
			if (axi_req.wvalid && rsp_reg.wready)
			begin
				w_ok_reg <= 1'b1;
				wdata_reg <= axi_req.wdata;
				wstrb0_reg <= axi_req.wstrb[0];
			end
			else if (wr_fire)
				w_ok_reg <= 1'b0;
		end
	end

	// ready pulses, write response and read response
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rsp_reg <= '0;
		else
		begin
			rsp_reg.awready <= axi_req.awvalid && !rsp_reg.awready &&
				!aw_ok_reg && !rsp_reg.bvalid;
			rsp_reg.wready <= axi_req.wvalid && !rsp_reg.wready &&
				!w_ok_reg && !rsp_reg.bvalid;
			if (wr_fire)
			begin
				rsp_reg.bvalid <= 1'b1;
				rsp_reg.bresp <= addr_hit(awaddr_reg) ?
					RESP_OKAY : RESP_SLVERR;
			end
			else if (axi_req.bready)
				rsp_reg.bvalid <= 1'b0;
			rsp_reg.arready <= axi_req.arvalid && !rsp_reg.arready &&
				!rsp_reg.rvalid;
			if (rd_fire)
			begin
				rsp_reg.rvalid <= 1'b1;
				rsp_reg.rdata <= rd_mux(axi_req.araddr[7:0]);
				rsp_reg.rresp <= addr_hit(axi_req.araddr[7:0]) ?
					RESP_OKAY : RESP_SLVERR;
			end
			else if (axi_req.rready)
				rsp_reg.rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// enable bit: set-only from software, cleared by any reset
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			watch_enable_reg <= MODE_RST[BIT_WATCH_EN];
		else if (int_any)
			watch_enable_reg <= 1'b0;
		else if (wr_fire && awaddr_reg == ADDR_MODE && wstrb0_reg)
			watch_enable_reg <= watch_enable_reg |
				wdata_reg[BIT_WATCH_EN];
	end

	// clock halt controls, cleared by any reset
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			{mosc_halt_reg, cpu_cut_reg, iosc_halt_reg} <= 3'b000;
		else if (int_any)
			{mosc_halt_reg, cpu_cut_reg, iosc_halt_reg} <= 3'b000;
		else if (wr_fire && wstrb0_reg)
		begin
			if (awaddr_reg == ADDR_MOSC)
				mosc_halt_reg <= wdata_reg[BIT_HS_HALT];
			if (awaddr_reg == ADDR_CPUCLK)
				cpu_cut_reg <= wdata_reg[BIT_HS_HALT];
			if (awaddr_reg == ADDR_IOSC && osc_stop_allowed)
				iosc_halt_reg <= wdata_reg[BIT_IOSC_HALT];
		end
	end

	// cause flags: power-on clear first, then read clear, sets win
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			reset_cause_register <= CAUSE_RST;
		else if (por_req)
			reset_cause_register <= CAUSE_RST;
		else
		begin
			reset_cause_register[BIT_WDT_FLAG] <= wdt_reset_req ||
				(reset_cause_register[BIT_WDT_FLAG] && !cause_read);
			reset_cause_register[BIT_LVI_FLAG] <= lvi_reset_req ||
				(reset_cause_register[BIT_LVI_FLAG] && !cause_read);
			reset_cause_register[BIT_WATCH_FLAG] <= detect ||
				(reset_cause_register[BIT_WATCH_FLAG] &&
				!cause_read);
		end
	end

	// chip reset pulse and monitor status
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			{clk_stop_reset_reg, monitor_active_reg} <= 2'b00;
		else
		begin
			clk_stop_reset_reg <= detect;
			monitor_active_reg <= mon_on && !detect;
		end
	end

	assign axi_rsp = rsp_reg;
	assign clk_stop_reset = clk_stop_reset_reg;
	assign monitor_active = monitor_active_reg;
	assign main_osc_halt = mosc_halt_reg;
	assign main_clock_cut = cpu_cut_reg;
	assign internal_osc_halt = iosc_halt_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_settle_done;
		state_reg == ST_SETTLE && settle_cnt_reg == '0 &&
			!suspend && !int_any;
	endsequence

	sequence s_fire;
		detect ##1 clk_stop_reset;
	endsequence

	enable_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
		watch_enable_reg && !int_any |=> watch_enable_reg)
		else $error("enable bit dropped without reset");
	monitor_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_fire |-> !watch_enable_reg &&
			reset_cause_register[BIT_WATCH_FLAG])
		else $error("monitor reset left enable or flag wrong");
	settle_start_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_settle_done |=> state_reg == ST_RUN)
		else $error("monitor did not start after settle");
	run_after_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		state_reg == ST_RUN && $past(state_reg) != ST_RUN |->
			$past(settle_cnt_reg) == '0)
		else $error("monitor ran before settle ended");
	suspend_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		suspend |=> state_reg != ST_RUN ##1 state_reg != ST_RUN)
		else $error("monitor ran during suspension");
	iosc_halt_a: assert property (@(posedge clk_sys) disable iff (rst)
		iosc_halt_reg |=> !monitor_active)
		else $error("monitor active with oscillator halted");
	stop_window_a: assert property (@(posedge clk_sys) disable iff (rst)
		detect |-> gap_cnt_reg == STOP_WINDOW_CYCLES - 5'h01 &&
			$past(mon_on))
		else $error("stop declared at wrong gap length");
	iosc_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
		!osc_stop_allowed && !iosc_halt_reg |=> !iosc_halt_reg)
		else $error("oscillator halt set while not allowed");
	wdt_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		wdt_reset_req && !por_req |=> reset_cause_register[BIT_WDT_FLAG]
			&& $stable(reset_cause_register[BIT_LVI_FLAG]) ||
			$past(lvi_reset_req) || $past(cause_read))
		else $error("watchdog flag not set alone");
	por_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		por_req |=> reset_cause_register == CAUSE_RST)
		else $error("power-on clear left a flag");
	read_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		cause_read && !int_any |=> reset_cause_register == CAUSE_RST)
		else $error("cause read did not clear flags");

endmodule

/* File: design/csm_pkg.sv */
package csm_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CAUSE = 8'h04;
	localparam logic [7:0] ADDR_MOSC = 8'h08;
	localparam logic [7:0] ADDR_CPUCLK = 8'h0C;
	localparam logic [7:0] ADDR_IOSC = 8'h10;
	localparam logic [7:0] ADDR_MCLK = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int BIT_WATCH_EN = 0;
	localparam int BIT_LVI_FLAG = 0;
	localparam int BIT_WATCH_FLAG = 1;
	localparam int BIT_WDT_FLAG = 4;
	localparam int BIT_HS_HALT = 7;
	localparam int BIT_IOSC_HALT = 0;
	localparam int BIT_MCLK_SEL = 1;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] CAUSE_RST = 8'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam logic [7:0] OSC_SETTLE_SEL_DEF = 8'h05;
	localparam longint SETTLE_HS_CYCLES = 65536;
	localparam longint SYS_CLK_KHZ = 25000;
	localparam longint SYS_PERIOD_NS = 40;
	localparam longint HS_CLK_KHZ_DEF = 10000;
	// settle time in system cycles, rounded up
	localparam longint SETTLE_CYCLES_DEF =
		(SETTLE_HS_CYCLES * SYS_CLK_KHZ + HS_CLK_KHZ_DEF - 1)
		/ HS_CLK_KHZ_DEF;
	localparam int SETTLE_W = 24;
	localparam logic [4:0] STOP_WINDOW_CYCLES = 5'h10;

	// ---------------------------------------------------------------
	// bus types
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} csm_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} csm_axi_rsp_t;

	typedef enum logic [1:0] {ST_SETTLE, ST_HOLD, ST_RUN} csm_state_t;

endpackage

/* File: test/csm_hs_osc.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------
// fast clock oscillator model
// ---------------------------------------------------------------
module csm_hs_osc (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// oscillator control
	input wire logic run,
	input wire logic [1:0] half,
	// fast clock pin
	output logic hs_clk_pin
);
	logic [1:0] cnt_reg;

	// toggle every half cycles; a halted oscillator freezes its level
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg <= 2'h0;
			hs_clk_pin <= 1'b0;
		end
		else if (run)
		begin
			if (cnt_reg >= half - 2'h1)
			begin
				cnt_reg <= 2'h0;
				hs_clk_pin <= ~hs_clk_pin;
			end
			else
				cnt_reg <= cnt_reg + 2'h1;
		end
	end
endmodule

/* File: test/csm_top_test.sv */
`timescale 1ns/1ns

// ---------------------------------------------------------------
// clock stop monitor bench
// ---------------------------------------------------------------
module csm_top_test;
	import csm_pkg::*;
	localparam int unsigned SETTLE = 40;
	logic clk_sys, rst, stop_mode, osc_ok, mclk_sel, por, wdt, low_voltage_detector, fail;
	logic [1:0] half;
	logic hs_pin, stop_rst, active, mosc_h, cut, iosc_h;
	csm_axi_req_t req;
	csm_axi_rsp_t rsp;
	logic [31:0] rd;
	logic [1:0] rr;
	logic [7:0] hadr [2];
	int n_mismatch = 0;
	int checked = 0;
	int n_rst = 0;

	csm_top #(.SETTLE_CYCLES(SETTLE)) uut (.clk_sys(clk_sys), .rst(rst),
		.axi_req(req), .axi_rsp(rsp), .hs_clk_pin(hs_pin),
		.stop_mode(stop_mode), .osc_stop_allowed(osc_ok),
		.main_clock_selected(mclk_sel), .por_req(por),
		.wdt_reset_req(wdt), .lvi_reset_req(low_voltage_detector),
		.clk_stop_reset(stop_rst), .monitor_active(active),
		.main_osc_halt(mosc_h), .main_clock_cut(cut),
		.internal_osc_halt(iosc_h));

	csm_hs_osc osc (.clk_sys(clk_sys), .rst(rst),
		.run(!mosc_h && !cut && !stop_mode && !fail), .half(half),
		.hs_clk_pin(hs_pin));

	// clock
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// count monitor reset pulses
	always @(posedge clk_sys)
		if (stop_rst === 1'b1)
			n_rst++;

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one write: address and data together, released as each is taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge clk_sys);
		req.awvalid <= 1'b1;
		req.awaddr <= {24'h0000_00, a};
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (!done && n < 50)
		begin
			@(posedge clk_sys);
			n++;
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid)
			begin
				rr = rsp.bresp;
				req.bready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
		begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// one read: data and response captured at the rvalid edge
	task automatic axi_rd(input logic [7:0] a);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge clk_sys);
		req.arvalid <= 1'b1;
		req.araddr <= {24'h0000_00, a};
		req.rready <= 1'b1;
		while (!done && n < 50)
		begin
			@(posedge clk_sys);
			n++;
			if (rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid)
			begin
				rd = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
		begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	// bounded wait for the monitor running flag
	task automatic wait_act(input logic e);
		int n;
		n = 0;
		while (active !== e && n < 200)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk({31'h0, active}, {31'h0, e});
		if (active !== e)
			give_verdict();
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		int junk;
		int n;
		req = '0;
		rst = 1'b1;
		{stop_mode, por, wdt, low_voltage_detector, fail} = 5'h00;
		osc_ok = 1'b0;
		mclk_sel = 1'b1;
		junk = $urandom(32'h9ea1d81c);
		half = 2'($urandom_range(3, 1));
		hadr = '{ADDR_MOSC, ADDR_CPUCLK};
		idle(4);
		rst <= 1'b0;
		axi_rd(ADDR_MODE);
		chk(rd, 32'h0000_0000);
		axi_rd(8'h1c);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		axi_wr(8'h1c, $urandom);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		$display("test reset values done");
		axi_wr(ADDR_MODE, $urandom | 32'h0000_0001);
		chk({30'h0, rr}, {30'h0, RESP_OKAY});
		chk({31'h0, active}, 32'h0000_0000);
		wait_act(1'b1);
		axi_rd(ADDR_STATUS);
		chk(rd, 32'h0000_0001);
		axi_rd(ADDR_MODE);
		chk(rd, 32'h0000_0001);
		axi_wr(ADDR_MODE, 32'h0000_0000);
		axi_rd(ADDR_MODE);
		chk(rd, 32'h0000_0001);
		$display("test enable done");
		for (int i = 0; i < 2; i++)
		begin
			half <= 2'($urandom_range(3, 1));
			axi_wr(hadr[i], 32'h0000_0080);
			chk({30'h0, mosc_h, cut}, 32'(2 >> i));
			axi_rd(hadr[i]);
			chk(rd, 32'h0000_0080);
			wait_act(1'b0);
			idle(40);
			axi_wr(hadr[i], 32'h0000_0000);
			wait_act(1'b1);
			chk({30'h0, mosc_h, cut}, 32'h0000_0000);
		end
		stop_mode <= 1'b1;
		wait_act(1'b0);
		idle(40);
		axi_rd(ADDR_STATUS);
		chk(rd, 32'h0000_0004);
		stop_mode <= 1'b0;
		wait_act(1'b1);
		chk(n_rst, 0);
		$display("test suspend done");
		axi_wr(ADDR_IOSC, 32'h0000_0001);
		chk({31'h0, iosc_h}, 32'h0000_0000);
		osc_ok <= 1'b1;
		axi_rd(ADDR_MCLK);
		chk(rd & 32'h0000_0002, 32'h0000_0002);
		axi_wr(ADDR_IOSC, 32'h0000_0001);
		chk({31'h0, iosc_h}, 32'h0000_0001);
		wait_act(1'b0);
		axi_wr(ADDR_IOSC, 32'h0000_0000);
		wait_act(1'b1);
		$display("test internal osc done");
		fail <= 1'b1;
		n = 0;
		while (n_rst == 0 && n < 60)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk(n_rst, 1);
		if (n_rst == 0)
			give_verdict();
		fail <= 1'b0;
		axi_rd(ADDR_CAUSE);
		chk(rd, 32'h0000_0002);
		axi_rd(ADDR_CAUSE);
		chk(rd, 32'h0000_0000);
		axi_rd(ADDR_MODE);
		chk(rd, 32'h0000_0000);
		$display("test clock loss done");
		@(posedge clk_sys) wdt <= 1'b1;
		@(posedge clk_sys) wdt <= 1'b0;
		low_voltage_detector <= 1'b1;
		@(posedge clk_sys) low_voltage_detector <= 1'b0;
		axi_rd(ADDR_CAUSE);
		chk(rd, 32'h0000_0011);
		@(posedge clk_sys) wdt <= 1'b1;
		@(posedge clk_sys) wdt <= 1'b0;
		por <= 1'b1;
		@(posedge clk_sys) por <= 1'b0;
		axi_rd(ADDR_CAUSE);
		chk(rd, 32'h0000_0000);
		$display("test reset causes done");
		axi_wr(ADDR_MODE, 32'h0000_0001);
		@(posedge clk_sys) rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		axi_rd(ADDR_MODE);
		chk(rd, 32'h0000_0000);
		chk({31'h0, active}, 32'h0000_0000);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule
